// [core/obpd_decoder.sv]
// Peripheral bus decoder with APB configuration registers
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module obpd_decoder #(
  parameter int WAITS = obpd_pkg::WAIT_STATES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // CPU bus request
  input wire logic cpu_req_i,
  input wire logic [23:0] cpu_addr_i,
  input wire logic cpu_byte_i,
  output logic cpu_ready_o,
  output logic cpu_err_o,
  // Internal target selects and claims, external select and segment line view
  output logic [obpd_pkg::NUM_TGT-1:0] tgt_sel_o,
  output logic [obpd_pkg::NUM_TGT-1:0] tgt_claim_o,
  output logic ext_sel_o,
  output logic [7:0] seg_lines_o
);
  initial begin
    if (WAITS != obpd_pkg::WAIT_STATES) begin
      $error("obpd_decoder: wait count is fixed by the bus timing");
    end
  end

  logic [15:0] syscfg_r;
  logic [15:0] periph_en_r;
  logic global_en;
  logic apb_wr;
  logic apb_bad;
  logic [obpd_pkg::NUM_TGT-1:0] hit;
  logic [obpd_pkg::NUM_TGT-1:0] claim;
  logic in_window;
  logic any_win_en;
  logic int_hit;
  logic [obpd_pkg::NUM_TGT-1:0] sel_r;
  logic ext_r;
  logic err_r;
  logic wait_busy;
  logic wait_done;
  logic ext_done_r;

  assign global_en = syscfg_r[obpd_pkg::SYSCFG_GLOBAL_BIT];
  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign apb_bad = paddr_i != obpd_pkg::REG_SYSCFG_OFF
    && paddr_i != obpd_pkg::REG_PERIPH_EN_OFF
    && paddr_i != obpd_pkg::REG_STATUS_OFF;

  // System configuration register; global bit sticks once set
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      syscfg_r <= obpd_pkg::SYSCFG_RST;
    end else if (apb_wr && paddr_i == obpd_pkg::REG_SYSCFG_OFF) begin
      syscfg_r <= pwdata_i[15:0] | syscfg_r;
    end
  end

  // Enable register, writable only before global enable
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      periph_en_r <= obpd_pkg::PERIPH_EN_RST;
    end else if (apb_wr && paddr_i == obpd_pkg::REG_PERIPH_EN_OFF && !global_en) begin
      periph_en_r <= pwdata_i[15:0] & obpd_pkg::PERIPH_EN_MASK;
    end
  end

  // APB answers in the access phase with no extra wait
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && apb_bad;

  // Read mux; status shows the live decode state
  always_comb begin
    prdata_o = 32'h0000_0000;
    if (psel_i) begin
      unique case (paddr_i)
        obpd_pkg::REG_SYSCFG_OFF: prdata_o = {16'h0000, syscfg_r};
        obpd_pkg::REG_PERIPH_EN_OFF: prdata_o = {16'h0000, periph_en_r};
        obpd_pkg::REG_STATUS_OFF: prdata_o = {7'h00, claim, 6'h00, ext_r, wait_busy,
          seg_lines_o};
        default: prdata_o = 32'h0000_0000;
      endcase
    end
  end

  // Per-target range compare and enable gate
  generate
    for (genvar g = 0; g < obpd_pkg::NUM_TGT; g++) begin : g_tgt
      localparam logic [23:0] LO = obpd_pkg::TGT_LO[g*24 +: 24];
      localparam logic [23:0] HI = obpd_pkg::TGT_HI[g*24 +: 24];
      localparam int BIT = int'(obpd_pkg::TGT_BIT[g*4 +: 4]);
      assign claim[g] = global_en && periph_en_r[BIT];
      assign hit[g] = claim[g] && cpu_addr_i >= LO && cpu_addr_i <= HI;
    end
  endgenerate

  assign in_window = cpu_addr_i >= obpd_pkg::WIN_LO && cpu_addr_i <= obpd_pkg::WIN_HI;
  assign any_win_en = |(periph_en_r & obpd_pkg::WINDOW_EN_MASK);
  assign int_hit = |hit;

  // Pins and interrupts claimed only by enabled units
  assign tgt_claim_o = claim;

  // Segment lines limited while a network unit is in use
  assign seg_lines_o = (claim[obpd_pkg::T_NET_A] || claim[obpd_pkg::T_NET_B])
    ? obpd_pkg::SEG_LINES_NET : obpd_pkg::SEG_LINES_ALL;

  // Two wait states per internal access
  obpd_waitgen #(
    .WAITS(WAITS)
  ) u_wait (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(cpu_req_i && int_hit && !cpu_byte_i && !wait_busy),
    .busy_o(wait_busy),
    .done_o(wait_done)
  );

  // Latch the decode for the access; a disabled range in a window that
  // still holds an enabled unit is left unclaimed and errors out
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_r <= '0;
      ext_r <= 1'b0;
      err_r <= 1'b0;
    end else if (cpu_req_i && !wait_busy && !ext_done_r && !err_r) begin
      if (in_window && cpu_byte_i && int_hit) begin
        sel_r <= '0;
        err_r <= 1'b1;
      end else if (int_hit) begin
        sel_r <= hit;
      end else if (!in_window || !global_en || !any_win_en) begin
        ext_r <= 1'b1;
      end else begin
        err_r <= 1'b1;
      end
    end else if (wait_done || ext_done_r || err_r) begin
      sel_r <= '0;
      ext_r <= 1'b0;
      err_r <= 1'b0;
    end
  end

  // External path completes one cycle after select
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_done_r <= 1'b0;
    end else begin
      ext_done_r <= ext_r && !ext_done_r;
    end
  end

  // Ready in the cycle after the last wait state, no turnaround cycle after
  assign cpu_ready_o = wait_done || ext_done_r || err_r;
  assign cpu_err_o = err_r;
  assign tgt_sel_o = sel_r;
  assign ext_sel_o = ext_r;
endmodule

// [core/obpd_pkg.sv]
// Package: register map, address windows, enable bit positions, timing counts
package obpd_pkg;
  // APB register byte offsets
  localparam logic [11:0] REG_SYSCFG_OFF = 12'h000;
  localparam logic [11:0] REG_PERIPH_EN_OFF = 12'h004;
  localparam logic [11:0] REG_STATUS_OFF = 12'h008;
  // System configuration field: global peripheral bus enable
  localparam int SYSCFG_GLOBAL_BIT = 2;
  // Peripheral enable register bit positions
  localparam int EN_NET_A = 0;
  localparam int EN_NET_B = 1;
  localparam int EN_XMEM1 = 2;
  localparam int EN_XMEM2 = 3;
  localparam int EN_CAL = 4;
  localparam int EN_XFLASH = 5;
  localparam int EN_PULSE = 6;
  localparam int EN_ASYNC = 7;
  localparam int EN_SYNC = 8;
  localparam int EN_TWO_WIRE = 9;
  localparam int EN_AUX = 10;
  localparam int EN_PORTS = 11;
  // Reset values: first network unit and small extension memory enabled
  localparam logic [15:0] PERIPH_EN_RST = 16'h0005;
  localparam logic [15:0] SYSCFG_RST = 16'h0000;
  // Writable enable bits; reserved bits read zero
  localparam logic [15:0] PERIPH_EN_MASK = 16'h0fff;
  // Bits of the shared peripheral window (all except memories)
  localparam logic [15:0] WINDOW_EN_MASK = 16'h0fd3;
  // Target count and index of each target
  localparam int NUM_TGT = 9;
  localparam int T_NET_A = 0;
  localparam int T_NET_B = 1;
  localparam int T_CAL = 2;
  localparam int T_PULSE = 3;
  localparam int T_ASYNC = 4;
  localparam int T_SYNC = 5;
  localparam int T_TWO_WIRE = 6;
  localparam int T_AUX = 7;
  localparam int T_PORTS = 8;
  // Window bounds and per-target range base/last (24-bit addresses)
  localparam logic [23:0] WIN_LO = 24'h00e800;
  localparam logic [23:0] WIN_HI = 24'h00efff;
  localparam logic [NUM_TGT*24-1:0] TGT_LO = {24'h00eb80, 24'h00eb00, 24'h00ea00,
    24'h00e800, 24'h00e900, 24'h00ec00, 24'h00ed00, 24'h00ee00, 24'h00ef00};
  localparam logic [NUM_TGT*24-1:0] TGT_HI = {24'h00ebff, 24'h00eb7f, 24'h00eaff,
    24'h00e8ff, 24'h00e9ff, 24'h00ecff, 24'h00edff, 24'h00eeff, 24'h00efff};
  localparam logic [NUM_TGT*4-1:0] TGT_BIT = {4'hb, 4'ha, 4'h9, 4'h8, 4'h7, 4'h6,
    4'h4, 4'h1, 4'h0};
  // Wait states per internal access; no turnaround states
  localparam int WAIT_STATES = 2;
  localparam int TURNAROUND_STATES = 0;
  // Segment lines available with a network unit active, else all eight
  localparam logic [7:0] SEG_LINES_NET = 8'h0f;
  localparam logic [7:0] SEG_LINES_ALL = 8'hff;
  // Access time figure at the core rate and the clock period
  localparam real ACCESS_NS = 62.5;
  localparam real CLK_PERIOD_NS = 10.0;
endpackage

// [core/obpd_waitgen.sv]
// Wait-state counter: holds ready low for a fixed number of cycles
`timescale 1ns/1ns
module obpd_waitgen #(
  parameter int WAITS = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Access start and completion
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  localparam int CW = (WAITS < 2) ? 1 : $clog2(WAITS + 1);
  initial begin
    if (WAITS < 0 || WAITS > 15) begin
      $error("obpd_waitgen: WAITS out of range");
    end
  end

  logic [CW-1:0] cnt_r;
  logic busy_r;

  // Count down the wait states, then flag done
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
    end else if (start_i && !busy_r) begin
      cnt_r <= CW'(WAITS);
      busy_r <= 1'b1;
    end else if (busy_r && cnt_r != '0) begin
      cnt_r <= cnt_r - CW'(1);
    end else begin
      busy_r <= 1'b0;
    end
  end

  assign busy_o = busy_r;
  assign done_o = busy_r && (cnt_r == '0);
endmodule

// [verif/obpd_decoder_properties.sv]
// Checker for the decoder's port behaviour
`timescale 1ns/1ns
module obpd_decoder_properties #(
  parameter int WAITS = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // CPU side
  input wire logic cpu_req_i,
  input wire logic [23:0] cpu_addr_i,
  input wire logic cpu_byte_i,
  input wire logic cpu_ready_o,
  input wire logic cpu_err_o,
  // Target side
  input wire logic [8:0] tgt_sel_o,
  input wire logic [8:0] tgt_claim_o,
  input wire logic ext_sel_o,
  input wire logic [7:0] seg_lines_o
);
  // Request address lies in the shared window
  wire logic in_win = (cpu_addr_i >= 24'h00e800) && (cpu_addr_i <= 24'h00efff);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  AST_SEL_CLAIMED: assert property ((tgt_sel_o & ~tgt_claim_o) == 9'h000)
    else $error("target selected without claim");
  AST_SEL_ONEHOT: assert property ($onehot0(tgt_sel_o))
    else $error("more than one target selected");
  AST_NETA_RANGE: assert property (tgt_sel_o[0] |-> cpu_addr_i[23:8] == 16'h00ef)
    else $error("first network unit selected outside its range");
  AST_AUX_RANGE: assert property (tgt_sel_o[7] |-> cpu_addr_i[23:7] == 17'h001d6)
    else $error("aux timer selected outside its range");
  AST_PORTS_RANGE: assert property (tgt_sel_o[8] |-> cpu_addr_i[23:7] == 17'h001d7)
    else $error("extra ports selected outside their range");
  AST_TWO_WAITS: assert property ($rose(|tgt_sel_o) |-> !cpu_ready_o ##1 !cpu_ready_o ##1 cpu_ready_o)
    else $error("internal access not ended after two wait states");
  AST_NO_TURN: assert property (cpu_ready_o && (|tgt_sel_o) |=> tgt_sel_o == 9'h000)
    else $error("select lingers after access end");
  AST_EXT_OUTSIDE: assert property ($rose(cpu_req_i) && !in_win |=> ext_sel_o ##1 cpu_ready_o)
    else $error("outside access not sent external");
  AST_BYTE_ERR: assert property ($rose(cpu_req_i) && cpu_byte_i && in_win && (|tgt_claim_o)
    |=> cpu_err_o && cpu_ready_o)
    else $error("byte access in window not refused");
  AST_SEG_LINES: assert property (seg_lines_o == ((tgt_claim_o[0] || tgt_claim_o[1]) ? 8'h0f : 8'hff))
    else $error("segment line count wrong");
  AST_ERR_READY: assert property (cpu_err_o |-> cpu_ready_o)
    else $error("error without access end");
  // Main scenarios reached
  COV_INTERNAL: cover property ($rose(|tgt_sel_o));
  COV_EXTERNAL: cover property ($rose(ext_sel_o));
  COV_REFUSED: cover property (cpu_err_o);
endmodule
bind obpd_decoder obpd_decoder_properties #(.WAITS(WAITS)) obpd_decoder_properties_inst (
  .clk_i(clk_i), .nrst_i(nrst_i), .cpu_req_i(cpu_req_i), .cpu_addr_i(cpu_addr_i),
  .cpu_byte_i(cpu_byte_i), .cpu_ready_o(cpu_ready_o), .cpu_err_o(cpu_err_o),
  .tgt_sel_o(tgt_sel_o), .tgt_claim_o(tgt_claim_o), .ext_sel_o(ext_sel_o),
  .seg_lines_o(seg_lines_o));

// [verif/obpd_cpu_model.sv]
// CPU bus master model that also watches the peripheral selects
`timescale 1ns/1ns
module obpd_cpu_model (
  // Clock
  input wire logic clk_i,
  // Request towards the decoder
  output logic cpu_req_o,
  output logic [23:0] cpu_addr_o,
  output logic cpu_byte_o,
  // Answer and selects seen
  input wire logic cpu_ready_i,
  input wire logic cpu_err_i,
  input wire logic [8:0] tgt_sel_i,
  input wire logic ext_sel_i
);
  // Idle bus
  initial begin
    cpu_req_o = 1'b0;
    cpu_addr_o = 24'h000000;
    cpu_byte_o = 1'b0;
  end
  // One access, held until ready is sampled high, then released
  task automatic access(input logic [23:0] a, input logic b, output int n, output logic e,
                        output logic [8:0] s, output logic x);
    n = 0;
    s = 9'h000;
    x = 1'b0;
    @(posedge clk_i);
    cpu_req_o <= 1'b1;
    cpu_addr_o <= a;
    cpu_byte_o <= b;
    do begin
      @(posedge clk_i);
      n++;
      s = s | tgt_sel_i;
      x = x | ext_sel_i;
    end while (cpu_ready_i !== 1'b1 && n < 40);
    e = cpu_err_i;
    cpu_req_o <= 1'b0;
    // Released lines show no stale value
    cpu_addr_o <= ~a;
    cpu_byte_o <= ~b;
  endtask
endmodule

// [verif/obpd_decoder_tb_top.sv]
// Self-checking bench for the peripheral decoder
`timescale 1ns/1ns
module obpd_decoder_tb_top;
  localparam logic [15:0] EN1 = 16'h0fc3;
  logic clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, rerr, hit;
  logic cpu_req_i, cpu_byte_i, cpu_ready_o, cpu_err_o, ext_sel_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [23:0] cpu_addr_i, a;
  logic [8:0] tgt_sel_o, tgt_claim_o;
  logic [7:0] seg_lines_o;
  int mismatches, checks_done, cycles, t;
  obpd_decoder obpd_decoder_inst (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cpu_req_i(cpu_req_i),
    .cpu_addr_i(cpu_addr_i), .cpu_byte_i(cpu_byte_i), .cpu_ready_o(cpu_ready_o),
    .cpu_err_o(cpu_err_o), .tgt_sel_o(tgt_sel_o), .tgt_claim_o(tgt_claim_o),
    .ext_sel_o(ext_sel_o), .seg_lines_o(seg_lines_o));
  obpd_cpu_model obpd_cpu_model_inst (.clk_i(clk_i), .cpu_req_o(cpu_req_i),
    .cpu_addr_o(cpu_addr_i), .cpu_byte_o(cpu_byte_i), .cpu_ready_i(cpu_ready_o),
    .cpu_err_i(cpu_err_o), .tgt_sel_i(tgt_sel_o), .ext_sel_i(ext_sel_o));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task finish_test;
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    rd = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // CPU access with expected edge count, error, select and external flag
  task automatic cpu(input logic [23:0] ad, input logic b, input int en, input logic ee,
                     input logic [8:0] es, input logic ex);
    int n;
    logic e, x;
    logic [8:0] s;
    obpd_cpu_model_inst.access(ad, b, n, e, s, x);
    chk(32'(n), 32'(en));
    chk(32'(e), 32'(ee));
    chk(32'(s), 32'(es));
    chk(32'(x), 32'(ex));
  endtask
  task automatic rst;
    nrst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test;
    end
  end
  initial begin
    {nrst_i, psel_i, penable_i, pwrite_i} = 4'h0;
    paddr_i = 12'h000;
    pwdata_i = 32'h00000000;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    rst;
    apb(1'b0, obpd_pkg::REG_PERIPH_EN_OFF, 32'h0);
    chk(rd, 32'h00000005);
    apb(1'b0, obpd_pkg::REG_SYSCFG_OFF, 32'h0);
    chk(rd, 32'h00000000);
    chk(32'(tgt_claim_o), 32'h0);
    cpu(24'h00ef00, 1'b0, 3, 1'b0, 9'h000, 1'b1);
    apb(1'b0, 12'h00c, 32'h0);
    chk(32'(rerr), 32'h1);
    // Calendar left off while the rest of the window is on
    apb(1'b1, obpd_pkg::REG_PERIPH_EN_OFF, 32'(EN1));
    apb(1'b1, obpd_pkg::REG_SYSCFG_OFF, 32'h00000004);
    apb(1'b1, obpd_pkg::REG_PERIPH_EN_OFF, 32'h0);
    apb(1'b0, obpd_pkg::REG_PERIPH_EN_OFF, 32'h0);
    chk(rd, 32'(EN1));
    chk(32'(seg_lines_o), 32'h0f);
    for (int k = 0; k < 18; k++) begin
      t = k / 2;
      a = k[0] ? obpd_pkg::TGT_HI[t*24 +: 24] : obpd_pkg::TGT_LO[t*24 +: 24];
      hit = EN1[obpd_pkg::TGT_BIT[t*4 +: 4]];
      // Internal: take edge, two wait states, then the edge that sees ready
      cpu(a, 1'b0, hit ? 4 : 2, !hit, hit ? 9'(1 << t) : 9'h000, 1'b0);
    end
    cpu(24'h00ef00, 1'b1, 2, 1'b1, 9'h000, 1'b0);
    cpu(24'h001000, 1'b0, 3, 1'b0, 9'h000, 1'b1);
    // Whole window off, global on
    rst;
    apb(1'b1, obpd_pkg::REG_PERIPH_EN_OFF, 32'h0);
    apb(1'b1, obpd_pkg::REG_SYSCFG_OFF, 32'h00000004);
    chk(32'(seg_lines_o), 32'hff);
    cpu(24'h00ed00, 1'b0, 3, 1'b0, 9'h000, 1'b1);
    finish_test;
  end
endmodule
